// ### rtl/oscs_top.sv
// Contract
// [RULE1] Status bit 7 shows whether the external clock has started.
// [RULE2] Status bit 5 shows the slow oscillator is stable.
// [RULE3] Status bit 4 shows the fast oscillator is stable.
// [RULE4] Stability flags count only while the source is requested.
// [RULE5] Held-on but unrequested oscillator reads stable flag zero.
// [RULE6] Status bit 0 is high while a main source switch waits.
// [RULE7] Control bit 1 keeps its oscillator powered in every mode.
// [RULE8] No oscillator clock reaches consumers without a request.
// [RULE9] Gate opens four oscillator cycles after request; held-on skips analog start.
// [RULE10] Six-bit frequency trim, loaded at reset from fuse-selected factory value.
// [RULE11] Freeze bit set blocks writes to both fast trim registers.
// [RULE12] Freeze bit loaded at reset from the fuse lock bit.
// [RULE13] Four-bit slope trim, loaded at reset with factory value.
// [RULE14] Software writes the unlock key, then guarded bits within four transfers.
// [RULE15] Guarded register unchanged when written without a valid unlock.
// [RULE16] External clock needs two cycles start-up; pin claimed on request.
// [RULE17] Read-only and reserved bits ignore writes; reserved bits read zero.
//
// The APB slave port is this design's own decision.
`timescale 1ns/10ps
module oscs_top #(
   parameter logic [7:0] FAST_ANALOG_TICKS = 8'h10,
   parameter logic [7:0] SLOW_ANALOG_TICKS = 8'h04,
   parameter logic [23:0] FREQ_TRIM_TABLE = 24'h820820,
   parameter logic [15:0] SLOPE_TRIM_TABLE = 16'h8888
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [oscs_pkg::ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Fuses
   input wire oscs_pkg::oscs_fuse_t osc_config_fuse,
   // Clock requests and main select
   input wire logic [1:0] main_clock_select,
   input wire logic fast_periph_req,
   input wire logic slow_periph_req,
   input wire logic ext_periph_req,
   // Oscillator cycle markers
   input wire logic fast_osc_tick,
   input wire logic slow_osc_tick,
   input wire logic ext_clock_tick,
   // Oscillator controls
   output logic fast_osc_power,
   output logic slow_osc_power,
   output logic fast_osc_clk_gate,
   output logic slow_osc_clk_gate,
   output logic ext_clk_gate,
   output logic external_clock_input_claim,
   output logic [1:0] main_clock_active,
   output logic [oscs_pkg::FREQ_TRIM_W-1:0] fast_osc_freq_trim,
   output logic [oscs_pkg::SLOPE_TRIM_W-1:0] fast_osc_temp_slope_trim,
   // Interrupt
   output logic irq
);

   // ----------------------------------------
   // State
   // ----------------------------------------
   logic fast_keep_q, fast_keep_d;
   logic slow_keep_q, slow_keep_d;
   logic [oscs_pkg::FREQ_TRIM_W-1:0] freq_trim_q, freq_trim_d;
   logic [oscs_pkg::SLOPE_TRIM_W-1:0] slope_trim_q, slope_trim_d;
   logic freeze_q, freeze_d;
   logic fuse_load_q;
   logic [1:0] active_src_q, active_src_d;
   logic [oscs_pkg::IRQ_W-1:0] irq_stat_q, irq_stat_d;
   logic [oscs_pkg::IRQ_W-1:0] irq_mask_q, irq_mask_d;
   logic [7:0] stat_prev_q;
   logic [31:0] prdata_q, prdata_d;
   logic pslverr_q, pslverr_d;

   oscs_pkg::oscs_osc_t fast_osc, slow_osc, ext_osc;

   // ----------------------------------------
   // APB decode
   // ----------------------------------------
   logic setup_phase, access_done, wr_done, rd_done;
   logic [oscs_pkg::ADDR_W-1:0] reg_idx;
   logic aligned;
   logic hit_status, hit_fast_ctrl, hit_freq, hit_slope, hit_slow_ctrl;
   logic hit_key, hit_irq_stat, hit_irq_mask, hit_any;
   logic guarded_hit, guarded_wr, unlocked, wr_allowed, trim_wr_ok;

   assign setup_phase = psel & ~penable;
   assign access_done = psel & penable;
   assign wr_done = access_done & pwrite;
   assign rd_done = access_done & ~pwrite;
   assign reg_idx = {{oscs_pkg::IDX_LSB{1'b0}}, paddr[oscs_pkg::ADDR_W-1:oscs_pkg::IDX_LSB]};
   assign aligned = (paddr[oscs_pkg::IDX_LSB-1:0] == 2'h0);
   assign hit_status = aligned & (reg_idx == oscs_pkg::IDX_MAIN_CLOCK_STATUS);
   assign hit_fast_ctrl = aligned & (reg_idx == oscs_pkg::IDX_FAST_OSC_CONTROL);
   assign hit_freq = aligned & (reg_idx == oscs_pkg::IDX_FAST_OSC_FREQ_TRIM);
   assign hit_slope = aligned & (reg_idx == oscs_pkg::IDX_FAST_OSC_SLOPE_TRIM);
   assign hit_slow_ctrl = aligned & (reg_idx == oscs_pkg::IDX_SLOW_OSC_CONTROL);
   assign hit_key = aligned & (reg_idx == oscs_pkg::IDX_GUARD_KEY);
   assign hit_irq_stat = aligned & (reg_idx == oscs_pkg::IDX_IRQ_STATUS);
   assign hit_irq_mask = aligned & (reg_idx == oscs_pkg::IDX_IRQ_MASK);
   assign hit_any = hit_status | hit_fast_ctrl | hit_freq | hit_slope | hit_slow_ctrl
                  | hit_key | hit_irq_stat | hit_irq_mask;

   // Guarded registers only change inside an unlock window
   assign guarded_hit = hit_fast_ctrl | hit_freq | hit_slope | hit_slow_ctrl;
   assign guarded_wr = wr_done & guarded_hit & unlocked;
   assign wr_allowed = guarded_wr;                       // see [RULE15]
   assign trim_wr_ok = wr_allowed & ~freeze_q;           // see [RULE11]

   oscs_unlock u_unlock (
      .pclk(pclk),
      .presetn(presetn),
      .key_write(wr_done & hit_key & (pwdata[7:0] == oscs_pkg::GUARD_KEY_VALUE)),
      .xfer_done(access_done),
      .guarded_write(guarded_wr),
      .unlocked(unlocked)
   );

   // ----------------------------------------
   // Clock requests and source switching
   // ----------------------------------------
   // Old source stays requested until the new one is stable, so main never stops
   logic fast_req, slow_req, ext_req, new_src_stable, switching;

   assign fast_req = fast_periph_req | (main_clock_select == oscs_pkg::SRC_FAST)
                   | (active_src_q == oscs_pkg::SRC_FAST);
   assign slow_req = slow_periph_req | (main_clock_select == oscs_pkg::SRC_SLOW)
                   | (active_src_q == oscs_pkg::SRC_SLOW);
   assign ext_req = ext_periph_req | (main_clock_select == oscs_pkg::SRC_EXT)
                  | (active_src_q == oscs_pkg::SRC_EXT);
   assign new_src_stable = (main_clock_select == oscs_pkg::SRC_FAST) ? fast_osc.stable :
                           (main_clock_select == oscs_pkg::SRC_SLOW) ? slow_osc.stable :
                           (main_clock_select == oscs_pkg::SRC_EXT) ? ext_osc.stable : 1'b0;
   assign switching = (main_clock_select != active_src_q);           // see [RULE6]
   assign active_src_d = (switching & new_src_stable) ? main_clock_select : active_src_q; // see [RULE6]

   oscs_osc_gate #(
      .ANALOG_TICKS(FAST_ANALOG_TICKS),
      .GATE_TICKS(oscs_pkg::OSC_GATE_TICKS)
   ) u_fast_gate (
      .pclk(pclk),
      .presetn(presetn),
      .request(fast_req),
      .keep_running(fast_keep_q),
      .osc_tick(fast_osc_tick),
      .osc(fast_osc)
   );

   oscs_osc_gate #(
      .ANALOG_TICKS(SLOW_ANALOG_TICKS),
      .GATE_TICKS(oscs_pkg::OSC_GATE_TICKS)
   ) u_slow_gate (
      .pclk(pclk),
      .presetn(presetn),
      .request(slow_req),
      .keep_running(slow_keep_q),
      .osc_tick(slow_osc_tick),
      .osc(slow_osc)
   );

   // External clock: no analog part, two cycles to start
   oscs_osc_gate #(
      .ANALOG_TICKS(oscs_pkg::EXT_ANALOG_TICKS),
      .GATE_TICKS(oscs_pkg::EXT_START_TICKS)
   ) u_ext_gate (
      .pclk(pclk),
      .presetn(presetn),
      .request(ext_req),
      .keep_running(1'b0),
      .osc_tick(ext_clock_tick),
      .osc(ext_osc)
   ); // see [RULE16]

   // ----------------------------------------
   // Status word
   // ----------------------------------------
   logic [7:0] status_word;

   always_comb begin
      status_word = 8'h00; // Reserved bits read zero, see [RULE17]
      status_word[oscs_pkg::BIT_EXT_STARTED] = ext_osc.stable;  // see [RULE1]
      status_word[oscs_pkg::BIT_SLOW_STABLE] = slow_osc.stable; // see [RULE2]
      status_word[oscs_pkg::BIT_FAST_STABLE] = fast_osc.stable; // see [RULE3]
      status_word[oscs_pkg::BIT_SWITCHING] = switching;         // see [RULE6]
   end

   // ----------------------------------------
   // Control and trim registers
   // ----------------------------------------
   // Fuse values are ports, so they load on the first edge after reset release
   logic [oscs_pkg::FREQ_TRIM_W-1:0] fuse_freq_trim;
   logic [oscs_pkg::SLOPE_TRIM_W-1:0] fuse_slope_trim;

   assign fuse_freq_trim = FREQ_TRIM_TABLE[osc_config_fuse.freq_select_fuse_bits * oscs_pkg::FREQ_TRIM_W
                                          +: oscs_pkg::FREQ_TRIM_W];   // see [RULE10]
   assign fuse_slope_trim = SLOPE_TRIM_TABLE[osc_config_fuse.freq_select_fuse_bits * oscs_pkg::SLOPE_TRIM_W
                                            +: oscs_pkg::SLOPE_TRIM_W]; // see [RULE13]

   assign fast_keep_d = (wr_allowed & hit_fast_ctrl) ? pwdata[oscs_pkg::BIT_KEEP_RUNNING] : fast_keep_q; // see [RULE7]
   assign slow_keep_d = (wr_allowed & hit_slow_ctrl) ? pwdata[oscs_pkg::BIT_KEEP_RUNNING] : slow_keep_q; // see [RULE7]
   assign freq_trim_d = fuse_load_q ? fuse_freq_trim :
                        (trim_wr_ok & hit_freq) ? pwdata[oscs_pkg::FREQ_TRIM_W-1:0] : freq_trim_q;
   assign slope_trim_d = fuse_load_q ? fuse_slope_trim :
                         (trim_wr_ok & hit_slope) ? pwdata[oscs_pkg::SLOPE_TRIM_W-1:0] : slope_trim_q;
   assign freeze_d = fuse_load_q ? osc_config_fuse.fuse_trim_freeze_bit : freeze_q; // see [RULE12]

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fast_keep_q <= oscs_pkg::CTRL_RESET[oscs_pkg::BIT_KEEP_RUNNING];
         slow_keep_q <= oscs_pkg::CTRL_RESET[oscs_pkg::BIT_KEEP_RUNNING];
         freq_trim_q <= '0;
         slope_trim_q <= '0;
         freeze_q <= 1'b1; // Frozen until the fuse says otherwise
         fuse_load_q <= 1'b1;
         active_src_q <= oscs_pkg::SRC_FAST;
      end else begin
         fast_keep_q <= fast_keep_d;
         slow_keep_q <= slow_keep_d;
         freq_trim_q <= freq_trim_d;
         slope_trim_q <= slope_trim_d;
         freeze_q <= freeze_d;
         fuse_load_q <= 1'b0;
         active_src_q <= active_src_d;
      end
   end

   // ----------------------------------------
   // Interrupt status and mask
   // ----------------------------------------
   // Rising stable flags and the falling switch flag post events; a read clears only what it returned, so new events win
   logic [oscs_pkg::IRQ_W-1:0] irq_events, irq_clear;

   assign irq_events[oscs_pkg::IRQ_EXT_STARTED] = status_word[oscs_pkg::BIT_EXT_STARTED]
                                                & ~stat_prev_q[oscs_pkg::BIT_EXT_STARTED];
   assign irq_events[oscs_pkg::IRQ_FAST_STABLE] = status_word[oscs_pkg::BIT_FAST_STABLE]
                                                & ~stat_prev_q[oscs_pkg::BIT_FAST_STABLE];
   assign irq_events[oscs_pkg::IRQ_SLOW_STABLE] = status_word[oscs_pkg::BIT_SLOW_STABLE]
                                                & ~stat_prev_q[oscs_pkg::BIT_SLOW_STABLE];
   assign irq_events[oscs_pkg::IRQ_SWITCH_DONE] = ~status_word[oscs_pkg::BIT_SWITCHING]
                                                & stat_prev_q[oscs_pkg::BIT_SWITCHING];
   assign irq_clear = (rd_done & hit_irq_stat) ? prdata_q[oscs_pkg::IRQ_W-1:0] : '0;
   assign irq_stat_d = (irq_stat_q & ~irq_clear) | irq_events;
   assign irq_mask_d = (wr_done & hit_irq_mask) ? pwdata[oscs_pkg::IRQ_W-1:0] : irq_mask_q;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_stat_q <= oscs_pkg::IRQ_RESET[oscs_pkg::IRQ_W-1:0];
         irq_mask_q <= oscs_pkg::IRQ_RESET[oscs_pkg::IRQ_W-1:0];
         stat_prev_q <= 8'h00;
      end else begin
         irq_stat_q <= irq_stat_d;
         irq_mask_q <= irq_mask_d;
         stat_prev_q <= status_word;
      end
   end

   // ----------------------------------------
   // Read data, captured in the setup cycle
   // ----------------------------------------
   logic [7:0] rd_byte;

   assign rd_byte = hit_status ? status_word :
                    hit_fast_ctrl ? {6'h00, fast_keep_q, 1'b0} :
                    hit_slow_ctrl ? {6'h00, slow_keep_q, 1'b0} :
                    hit_freq ? {2'h0, freq_trim_q} :
                    hit_slope ? {freeze_q, 3'h0, slope_trim_q} :
                    hit_irq_stat ? {4'h0, irq_stat_q} :
                    hit_irq_mask ? {4'h0, irq_mask_q} : 8'h00; // see [RULE17]
   assign prdata_d = (setup_phase & ~pwrite) ? {24'h000000, rd_byte} : prdata_q;
   assign pslverr_d = setup_phase ? ~hit_any : pslverr_q;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_q <= 32'h00000000;
         pslverr_q <= 1'b0;
      end else begin
         prdata_q <= prdata_d;
         pslverr_q <= pslverr_d;
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign prdata = prdata_q;
   assign pready = access_done; // One access cycle, never stretched
   assign pslverr = access_done & pslverr_q;
   assign fast_osc_power = fast_osc.powered;
   assign slow_osc_power = slow_osc.powered;
   assign fast_osc_clk_gate = fast_osc.clk_gate_open; // see [RULE8]
   assign slow_osc_clk_gate = slow_osc.clk_gate_open; // see [RULE8]
   assign ext_clk_gate = ext_osc.clk_gate_open;
   assign external_clock_input_claim = ext_req;        // see [RULE16]
   assign main_clock_active = active_src_q;
   assign fast_osc_freq_trim = freq_trim_q;
   assign fast_osc_temp_slope_trim = slope_trim_q;
   assign irq = |(irq_stat_q & irq_mask_q);

endmodule : oscs_top

// ### shared/oscs_pkg.sv
package oscs_pkg;

   // ----------------------------------------
   // Register indices (byte address = index * 4)
   // ----------------------------------------
   localparam logic [7:0] IDX_MAIN_CLOCK_STATUS = 8'h03;
   localparam logic [7:0] IDX_FAST_OSC_CONTROL = 8'h10;
   localparam logic [7:0] IDX_FAST_OSC_FREQ_TRIM = 8'h11;
   localparam logic [7:0] IDX_FAST_OSC_SLOPE_TRIM = 8'h12;
   localparam logic [7:0] IDX_SLOW_OSC_CONTROL = 8'h18;
   localparam logic [7:0] IDX_GUARD_KEY = 8'h20;
   localparam logic [7:0] IDX_IRQ_STATUS = 8'h21;
   localparam logic [7:0] IDX_IRQ_MASK = 8'h22;
   localparam int ADDR_W = 8;
   localparam int IDX_LSB = 2;

   // ----------------------------------------
   // Field positions and reset values
   // ----------------------------------------
   localparam int BIT_EXT_STARTED = 7;
   localparam int BIT_SLOW_STABLE = 5;
   localparam int BIT_FAST_STABLE = 4;
   localparam int BIT_SWITCHING = 0;
   localparam int BIT_KEEP_RUNNING = 1;
   localparam int BIT_TRIM_FREEZE = 7;
   localparam int FREQ_TRIM_W = 6;
   localparam int SLOPE_TRIM_W = 4;
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [7:0] IRQ_RESET = 8'h00;

   // Interrupt status bits
   localparam int IRQ_EXT_STARTED = 0;
   localparam int IRQ_FAST_STABLE = 1;
   localparam int IRQ_SLOW_STABLE = 2;
   localparam int IRQ_SWITCH_DONE = 3;
   localparam int IRQ_W = 4;

   // ----------------------------------------
   // Unlock and timing
   // ----------------------------------------
   localparam logic [7:0] GUARD_KEY_VALUE = 8'h5a; // Arbitrary key value
   localparam logic [2:0] GUARD_WINDOW = 3'h4;     // Transfers allowed after the key
   localparam logic [7:0] OSC_GATE_TICKS = 8'h04;  // Oscillator cycles to open the gate
   localparam logic [7:0] EXT_START_TICKS = 8'h02; // External clock start-up cycles
   localparam logic [7:0] EXT_ANALOG_TICKS = 8'h00;

   // Main clock source select codes
   localparam logic [1:0] SRC_FAST = 2'h0;
   localparam logic [1:0] SRC_SLOW = 2'h1;
   localparam logic [1:0] SRC_EXT = 2'h3;

   // ----------------------------------------
   // Types
   // ----------------------------------------
   typedef enum logic [4:0] {
      OSC_OFF = 5'b00001,
      OSC_START = 5'b00010,
      OSC_READY = 5'b00100,
      OSC_GATE = 5'b01000,
      OSC_OPEN = 5'b10000
   } oscs_state_t;

   typedef struct packed {
      logic powered;
      logic stable;
      logic clk_gate_open;
   } oscs_osc_t;

   typedef struct packed {
      logic [1:0] freq_select_fuse_bits;
      logic fuse_trim_freeze_bit;
   } oscs_fuse_t;

endpackage : oscs_pkg

// ### rtl/oscs_osc_gate.sv
`timescale 1ns/10ps
module oscs_osc_gate #(
   parameter logic [7:0] ANALOG_TICKS = 8'h08,
   parameter logic [7:0] GATE_TICKS = 8'h04
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Control
   input wire logic request,
   input wire logic keep_running,
   input wire logic osc_tick,
   // Result
   output oscs_pkg::oscs_osc_t osc
);

   oscs_pkg::oscs_state_t state_q, state_d;
   logic [7:0] cnt_q, cnt_d;
   logic powered;

   // Powered while used or while held on by software
   assign powered = request | keep_running;

   // ----------------------------------------
   // Start-up sequencing
   // ----------------------------------------
   always_comb begin
      state_d = state_q;
      cnt_d = cnt_q;
      unique case (state_q)
         oscs_pkg::OSC_OFF: begin
            cnt_d = 8'h00;
            if (powered) begin
               state_d = (ANALOG_TICKS == 8'h00) ? oscs_pkg::OSC_READY : oscs_pkg::OSC_START;
            end
         end
         oscs_pkg::OSC_START: begin
            if (!powered) begin
               state_d = oscs_pkg::OSC_OFF;
            end else if (osc_tick) begin
               cnt_d = cnt_q + 8'h01;
               if (cnt_q == ANALOG_TICKS - 8'h01) begin
                  state_d = oscs_pkg::OSC_READY;
                  cnt_d = 8'h00;
               end
            end
         end
         oscs_pkg::OSC_READY: begin
            cnt_d = 8'h00;
            if (!powered) begin
               state_d = oscs_pkg::OSC_OFF;
            end else if (request) begin
               state_d = oscs_pkg::OSC_GATE; // Held-on oscillator skips analog start-up, see [RULE9]
            end
         end
         oscs_pkg::OSC_GATE: begin
            if (!powered) begin
               state_d = oscs_pkg::OSC_OFF;
            end else if (!request) begin
               state_d = oscs_pkg::OSC_READY;
            end else if (osc_tick) begin
               cnt_d = cnt_q + 8'h01;
               if (cnt_q == GATE_TICKS - 8'h01) begin
                  state_d = oscs_pkg::OSC_OPEN; // see [RULE9]
               end
            end
         end
         oscs_pkg::OSC_OPEN: begin
            if (!powered) begin
               state_d = oscs_pkg::OSC_OFF;
            end else if (!request) begin
               state_d = oscs_pkg::OSC_READY;
            end
         end
         default: begin
            state_d = oscs_pkg::OSC_OFF;
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q <= oscs_pkg::OSC_OFF;
         cnt_q <= 8'h00;
      end else begin
         state_q <= state_d;
         cnt_q <= cnt_d;
      end
   end

   // Gate only open while requested, so held-on alone gives no clock
   assign osc.powered = powered;                                  // see [RULE7]
   assign osc.clk_gate_open = (state_q == oscs_pkg::OSC_OPEN);    // see [RULE8]
   assign osc.stable = (state_q == oscs_pkg::OSC_OPEN) & request; // see [RULE4] see [RULE5]

endmodule : oscs_osc_gate

// ### rtl/oscs_unlock.sv
`timescale 1ns/10ps
module oscs_unlock (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Bus events
   input wire logic key_write,
   input wire logic xfer_done,
   input wire logic guarded_write,
   // Window state
   output logic unlocked
);

   logic [2:0] left_q, left_d;

   // ----------------------------------------
   // Window of a few transfers after the key
   // ----------------------------------------
   // A guarded write consumes the window so one key buys one change
   always_comb begin
      left_d = left_q;
      if (key_write) begin
         left_d = oscs_pkg::GUARD_WINDOW;
      end else if (guarded_write) begin
         left_d = 3'h0;
      end else if (xfer_done && left_q != 3'h0) begin
         left_d = left_q - 3'h1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         left_q <= 3'h0;
      end else begin
         left_q <= left_d;
      end
   end

   assign unlocked = (left_q != 3'h0); // see [RULE14]

endmodule : oscs_unlock

// ### bench/oscs_top_properties.sv
`timescale 1ns/10ps
module oscs_checker (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Bus
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic pslverr,
   // Requests and ticks
   input wire logic [1:0] main_clock_select,
   input wire logic [1:0] main_clock_active,
   input wire logic fast_periph_req,
   input wire logic ext_periph_req,
   input wire logic fast_osc_tick,
   input wire logic ext_clock_tick,
   // Outputs watched
   input wire logic fast_osc_power,
   input wire logic fast_osc_clk_gate,
   input wire logic ext_clk_gate,
   input wire logic external_clock_input_claim,
   input wire logic [5:0] fast_osc_freq_trim
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // ----------------------------------------
   // Oscillator power and gates
   // ----------------------------------------
   a_fast_power_req: assert property (fast_periph_req |-> fast_osc_power)
      else $error("fast power low under request");
   // Gate is registered, so its cause is one cycle back
   a_fast_gate_req: assert property (fast_osc_clk_gate |-> $past(fast_periph_req) ||
      $past(main_clock_select) == oscs_pkg::SRC_FAST || $past(main_clock_active) == oscs_pkg::SRC_FAST)
      else $error("fast gate open without request");
   a_ext_gate_req: assert property (ext_clk_gate |-> $past(ext_periph_req) ||
      $past(main_clock_select) == oscs_pkg::SRC_EXT || $past(main_clock_active) == oscs_pkg::SRC_EXT)
      else $error("ext gate open without request");
   a_fast_gate_tick: assert property ($rose(fast_osc_clk_gate) |-> $past(fast_osc_tick))
      else $error("fast gate opened off a tick");
   a_ext_gate_tick: assert property ($rose(ext_clk_gate) |-> $past(ext_clock_tick))
      else $error("ext gate opened off a tick");
   a_ext_claim_req: assert property (ext_periph_req |-> external_clock_input_claim)
      else $error("ext pin not claimed");
   // ----------------------------------------
   // Bus side
   // ----------------------------------------
   a_err_in_access: assert property (pslverr |-> psel && penable)
      else $error("error outside access phase");
   // Skip the fuse load edge right after reset
   a_trim_hold: assert property ($past(presetn, 2) && !$past(psel && penable && pwrite)
      |-> $stable(fast_osc_freq_trim)) else $error("trim moved without a write");
endmodule : oscs_checker

bind oscs_top oscs_checker u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .pslverr(pslverr), .main_clock_select(main_clock_select),
   .main_clock_active(main_clock_active), .fast_periph_req(fast_periph_req), .ext_periph_req(ext_periph_req),
   .fast_osc_tick(fast_osc_tick), .ext_clock_tick(ext_clock_tick), .fast_osc_power(fast_osc_power),
   .fast_osc_clk_gate(fast_osc_clk_gate), .ext_clk_gate(ext_clk_gate),
   .external_clock_input_claim(external_clock_input_claim), .fast_osc_freq_trim(fast_osc_freq_trim));

// ### bench/oscs_top_tb.sv
`timescale 1ns/10ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin n_mismatch++; \
   $display("[ERR] %0t got %h want %h", $time, a, b); end end
module oscs_top_tb;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, irq;
   logic [7:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata, rd_data;
   logic [1:0] sel = 0, act;
   logic freq = 0, sreq = 0, ereq = 0, ft = 0, st = 0, et = 0, rd_err;
   logic fpw, spw, fg, sg, eg, claim;
   logic [5:0] ftrim;
   logic [3:0] strim, cnt = 0;
   oscs_pkg::oscs_fuse_t fuse = 3'h0;
   int n_mismatch = 0, n_tests = 0;
   oscs_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .osc_config_fuse(fuse), .main_clock_select(sel), .fast_periph_req(freq), .slow_periph_req(sreq),
      .ext_periph_req(ereq), .fast_osc_tick(ft), .slow_osc_tick(st), .ext_clock_tick(et),
      .fast_osc_power(fpw), .slow_osc_power(spw), .fast_osc_clk_gate(fg), .slow_osc_clk_gate(sg),
      .ext_clk_gate(eg), .external_clock_input_claim(claim), .main_clock_active(act),
      .fast_osc_freq_trim(ftrim), .fast_osc_temp_slope_trim(strim), .irq(irq));
   // ----------------------------------------
   // Clock and oscillator tick pulses
   // ----------------------------------------
   always #5 pclk = ~pclk;
   always @(posedge pclk) begin
      cnt <= cnt + 4'h1;
      ft <= cnt[0];
      et <= cnt[0];
      st <= (cnt[1:0] == 2'h3);
   end
   // ----------------------------------------
   // APB tasks; request held until pready edge
   // ----------------------------------------
   task automatic xfer(input logic w, input logic [7:0] idx, input logic [7:0] d);
      @(posedge pclk);
      psel <= 1;
      pwrite <= w;
      paddr <= {idx[5:0], 2'b00};
      pwdata <= {24'h0, d};
      @(posedge pclk);
      penable <= 1;
      do @(posedge pclk); while (pready !== 1'b1); // Only the watchdog ends a hang
      rd_data = prdata;
      rd_err = pslverr;
      psel <= 0;
      penable <= 0;
   endtask : xfer
   task automatic poll(input int b, input logic v);
      int i;
      i = 0;
      xfer(0, oscs_pkg::IDX_MAIN_CLOCK_STATUS, 8'h0);
      while (rd_data[b] !== v && i < 200) begin xfer(0, oscs_pkg::IDX_MAIN_CLOCK_STATUS, 8'h0); i++; end
   endtask : poll
   task automatic do_reset;
      presetn <= 0;
      repeat (2) @(posedge pclk);
      presetn <= 1;
      repeat (2) @(posedge pclk);
   endtask : do_reset
   task automatic tally_and_finish;
      $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : tally_and_finish
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      do_reset();
      xfer(0, 8'h11, 8'h0); `CHK(rd_data, 32'h20)
      `CHK(ftrim, 6'h20)
      xfer(0, 8'h12, 8'h0); `CHK(rd_data, 32'h08)
      `CHK(strim, 4'h8)
      xfer(0, 8'h18, 8'h0); `CHK(rd_data, 32'h0)
      xfer(1, 8'h10, 8'h02); xfer(0, 8'h10, 8'h0); `CHK(rd_data, 32'h0)
      xfer(1, 8'h20, oscs_pkg::GUARD_KEY_VALUE); xfer(1, 8'h18, 8'h02);
      xfer(0, 8'h18, 8'h0); `CHK(rd_data, 32'h02)
      `CHK(spw, 1'b1)
      poll(4, 1); `CHK(rd_data, 32'h10)
      `CHK(sg, 1'b0)
      xfer(1, 8'h20, oscs_pkg::GUARD_KEY_VALUE); xfer(1, 8'h11, 8'h3f);
      xfer(0, 8'h11, 8'h0); `CHK(rd_data, 32'h3f)
      xfer(1, 8'h03, 8'hff); xfer(0, 8'h03, 8'h0); `CHK(rd_data, 32'h10)
      xfer(0, 8'h05, 8'h0); `CHK({rd_err, rd_data}, 33'h100000000)
      // External clock and fast oscillator requested by peripherals
      ereq <= 1;
      freq <= 1;
      @(posedge pclk); #1 `CHK(claim, 1'b1)
      poll(7, 1); `CHK(rd_data[7], 1'b1)
      sel <= oscs_pkg::SRC_SLOW;
      xfer(0, 8'h03, 8'h0); `CHK(rd_data[0], 1'b1)
      poll(0, 0); `CHK(act, oscs_pkg::SRC_SLOW)
      `CHK(rd_data[5:4], 2'h3)
      // Events are sticky; unmasking raises irq, a status read clears it
      xfer(1, 8'h22, 8'h0f); @(posedge pclk); `CHK(irq, 1'b1)
      xfer(0, 8'h21, 8'h0); `CHK(rd_data, 32'h0f)
      @(posedge pclk); `CHK(irq, 1'b0)
      xfer(1, 8'h22, 8'h0); xfer(0, 8'h22, 8'h0); `CHK(rd_data, 32'h0)
      // Freeze from fuse blocks trim writes even when unlocked
      fuse <= 3'h1;
      do_reset();
      xfer(1, 8'h20, oscs_pkg::GUARD_KEY_VALUE); xfer(1, 8'h11, 8'h05);
      xfer(0, 8'h11, 8'h0); `CHK(rd_data, 32'h20)
      xfer(0, 8'h12, 8'h0); `CHK(rd_data, 32'h88)
      tally_and_finish();
   end
   // Watchdog, well past the expected run of under two hundred cycles
   initial begin
      #300000;
      n_mismatch++;
      tally_and_finish();
   end
endmodule : oscs_top_tb
